// File: core/fpch_consts.vh
`ifndef FPCH_CONSTS_VH
`define FPCH_CONSTS_VH
// ***************************************
// function codes and exception codes
// ***************************************
`define FC_RD_COILS  8'h01
`define FC_RD_HREG   8'h03
`define FC_WR_COIL   8'h05
`define FC_WR_REG    8'h06
`define FC_DIAG      8'h08
`define FC_EVT_CNT   8'h0B
`define FC_WR_COILS  8'h0F
`define FC_WR_REGS   8'h10
`define FC_REP_ID    8'h11
`define EXC_BIT      8'h80
`define EX_FUNC      8'h01
`define EX_ADDR      8'h02
`define EX_VALUE     8'h03
`define EX_FAIL      8'h04
// ***************************************
// diagnostics sub-functions
// ***************************************
`define SUB_RESTART  16'h0001
`define SUB_DIAG_REG 16'h0002
`define SUB_CLEAR    16'h000A
`define SUB_BUS_MSG  16'h000B
`define SUB_COMM_ERR 16'h000C
`define SUB_EXC_ERR  16'h000D
`define SUB_FOL_MSG  16'h000E
// ***************************************
// addressing and register map
// ***************************************
`define BCAST_ADDR   8'h00
`define MAX_ADDR     8'hF7
`define ADDR_ADJ     16'h0001
`define REG_ERR      16'h0007
`define REG_IDX      16'h0009
`define REG_CTW      16'hC350
`define REG_REF      16'hC35A
`define REG_STW      16'hC418
`define REG_MAV      16'hC422
`define PAR_FIRST    16'h000A
`define PAR_LAST     17'h0C34F
`define PAR_DIV      16'h000A
`define MAX_REGS     16'h000A
`define COIL_TOTAL   17'h00041
`define COIL_WR_LIM  17'h00020
`define COIL_PERSIST 16'h0040
`define COIL_ON      16'hFF00
`define COIL_OFF     16'h0000
// ***************************************
// frame layout and fill values
// ***************************************
`define LEN_FIX      6'h06
`define LEN_BARE     6'h02
`define LEN_EXC      6'h03
`define LEN_MHDR     6'h07
`define RX_FULL      6'h20
`define SPACE_CHR    8'h20
`define RUN_ON       8'hFF
`define FOLLOWER_ID  8'h5A
`define CRC_INIT     16'hFFFF
`define CRC_POLY     16'hA001
`define DIAG_CRC_BIT 0
`define DIAG_EXC_BIT 1
`endif

// File: core/fpch_crc16.v
`timescale 1ns/1ps
`include "fpch_consts.vh"
module fpch_crc16 (
    input  wire [15:0] i_crc,
    input  wire [7:0]  i_byte,
    output reg  [15:0] o_crc
);
    integer b;
    // ***************************************
    // one byte of the reflected check update
    // ***************************************
    always @* begin
        o_crc = i_crc ^ {8'h00, i_byte};
        for (b = 0; b < 8; b = b + 1) begin
            if (o_crc[0]) begin
                o_crc = (o_crc >> 1) ^ `CRC_POLY;
            end else begin
                o_crc = o_crc >> 1;
            end
        end
    end
endmodule // fpch_crc16

// File: core/fpch_cmd.v
`timescale 1ns/1ps
`include "fpch_consts.vh"
module fpch_cmd (
    input  wire        i_core_clk,
    input  wire        i_rstn,
    input  wire [7:0]  i_own_addr,
    input  wire        i_rx_valid,
    input  wire [7:0]  i_rx_data,
    input  wire        i_rx_end,
    input  wire        i_rx_crc_ok,
    input  wire        i_tx_ready,
    output reg         o_tx_valid,
    output reg  [7:0]  o_tx_data,
    output reg         o_tx_last,
    output reg         o_busy,
    input  wire        i_drv_ready,
    output reg         o_par_req,
    output reg         o_par_we,
    output reg  [15:0] o_par_num,
    output reg  [3:0]  o_par_ofs,
    output reg  [15:0] o_par_idx,
    output reg  [15:0] o_par_wdata,
    output reg         o_par_persist,
    input  wire        i_par_ack,
    input  wire [15:0] i_par_rdata,
    input  wire        i_par_err,
    input  wire [15:0] i_par_code,
    input  wire        i_par_text,
    input  wire [3:0]  i_par_words,
    input  wire [15:0] i_status_word,
    input  wire [15:0] i_main_actual,
    output reg  [15:0] o_ctrl_word,
    output reg  [15:0] o_bus_ref
);
    localparam S_IDLE  = 3'd0;
    localparam S_CHK   = 3'd1;
    localparam S_REG   = 3'd2;
    localparam S_PWAIT = 3'd3;
    localparam S_SEND  = 3'd4;

    reg  [2:0]  st_q;
    reg  [7:0]  rxb [0:31];
    reg  [7:0]  txb [0:31];
    reg  [5:0]  rx_len_q;
    reg         rx_ovf_q;
    reg  [5:0]  tx_len_q;
    reg  [5:0]  tx_pos_q;
    reg  [15:0] crc_q;
    wire [15:0] crc_d;
    reg  [15:0] idx_q;
    reg  [15:0] err_q;
    reg  [15:0] diag_q;
    reg  [15:0] bus_cnt_q;
    reg  [15:0] cerr_cnt_q;
    reg  [15:0] exc_cnt_q;
    reg  [15:0] fol_cnt_q;
    reg  [15:0] evt_cnt_q;
    reg  [3:0]  ri_q;
    reg         text_q;
    reg  [3:0]  words_q;
    reg  [7:0]  ex;
    reg  [71:0] cmask;
    reg  [71:0] cwd;
    reg  [71:0] cnew;
    reg  [15:0] lrd;
    integer     k;
    integer     n;

    wire [7:0]  fc    = rxb[1];
    wire [15:0] adr   = {rxb[2], rxb[3]};
    wire [15:0] qty   = {rxb[4], rxb[5]};
    wire [7:0]  bc    = rxb[6];
    wire        bcast = (rxb[0] == `BCAST_ADDR);
    wire        own_ok = (i_own_addr != `BCAST_ADDR) && (i_own_addr <= `MAX_ADDR);
    wire        for_us = bcast || (own_ok && rxb[0] == i_own_addr);
    wire        rd_fc = (fc == `FC_RD_HREG) || (fc == `FC_RD_COILS);
    wire        reg_fc = (fc == `FC_RD_HREG) || (fc == `FC_WR_REG) || (fc == `FC_WR_REGS);
    wire [15:0] cnt   = (fc == `FC_WR_REG) ? 16'h0001 : qty;
    wire [15:0] rbase = adr + `ADDR_ADJ;
    wire [16:0] rend  = {1'b0, rbase} + {1'b0, cnt} - 17'h00001;
    wire [16:0] cend  = {1'b0, adr} + {1'b0, qty};
    wire [15:0] cur   = rbase + {12'h000, ri_q};
    wire [15:0] par_num = cur / `PAR_DIV;
    wire [15:0] par_ofs = cur - par_num * `PAR_DIV;
    // zero bytes of a text read go out as spaces
    wire [7:0]  rd_hi = (i_par_text && i_par_rdata[15:8] == 8'h00) ? `SPACE_CHR
                      : i_par_rdata[15:8];
    wire [7:0]  rd_lo = (i_par_text && i_par_rdata[7:0] == 8'h00) ? `SPACE_CHR
                      : i_par_rdata[7:0];
    wire        cur_par = (cur >= `PAR_FIRST) && ({1'b0, cur} <= `PAR_LAST);
    wire [64:0] coil_v = {o_par_persist, i_main_actual, i_status_word, o_bus_ref, o_ctrl_word};
    wire [71:0] coil_rd = ({7'h00, coil_v} >> adr[6:0]) & cmask;
    wire [7:0]  wlen  = {2'b00, `LEN_MHDR} + bc;
    wire [15:0] cbytes = (qty + 16'h0007) >> 3;
    wire        loc_rd = (rbase == `REG_ERR) || (rbase == `REG_IDX) || (rbase == `REG_CTW)
                      || (rbase == `REG_REF) || (rbase == `REG_STW) || (rbase == `REG_MAV);
    wire        loc_wr = (rbase == `REG_IDX) || (rbase == `REG_CTW) || (rbase == `REG_REF);
    wire        par_rng = (rbase >= `PAR_FIRST) && (rend <= `PAR_LAST);
    wire        rng_ok = par_rng || (cnt == 16'h0001 && (fc == `FC_RD_HREG ? loc_rd : loc_wr));
    wire        cw_ok = (cend <= `COIL_WR_LIM) || (adr == `COIL_PERSIST && qty == 16'h0001);
    wire        sub_ok = ((adr == `SUB_RESTART) || (adr == `SUB_DIAG_REG)
                      || (adr == `SUB_CLEAR) || (adr == `SUB_BUS_MSG) || (adr == `SUB_COMM_ERR)
                      || (adr == `SUB_EXC_ERR) || (adr == `SUB_FOL_MSG));

    fpch_crc16 u_crc (
        .i_crc  (crc_q),
        .i_byte (txb[tx_pos_q[4:0]]),
        .o_crc  (crc_d)
    );

    // ***************************************
    // request checks; register values are never judged, a single coil value must be on or off
    // ***************************************
    always @* begin
        ex = 8'h00;
        if (rx_ovf_q) begin
            ex = `EX_VALUE;
        end else begin
            case (fc)
                `FC_RD_COILS: begin
                    if (rx_len_q != `LEN_FIX || qty == 16'h0000) ex = `EX_VALUE;
                    else if (cend > `COIL_TOTAL) ex = `EX_ADDR;
                end
                `FC_WR_COIL: begin
                    if (rx_len_q != `LEN_FIX || (qty != `COIL_ON && qty != `COIL_OFF))
                        ex = `EX_VALUE;
                    else if (!(({1'b0, adr} < `COIL_WR_LIM) || adr == `COIL_PERSIST))
                        ex = `EX_ADDR;
                end
                `FC_WR_COILS: begin
                    if (qty == 16'h0000 || {8'h00, bc} != cbytes || {2'b00, rx_len_q} != wlen)
                        ex = `EX_VALUE;
                    else if (!cw_ok) ex = `EX_ADDR;
                end
                `FC_RD_HREG, `FC_WR_REG, `FC_WR_REGS: begin
                    if (fc == `FC_WR_REGS && (qty == 16'h0000 || qty > `MAX_REGS
                        || {8'h00, bc} != {qty[14:0], 1'b0}
                        || {2'b00, rx_len_q} != wlen)) ex = `EX_VALUE;
                    else if (fc != `FC_WR_REGS && rx_len_q != `LEN_FIX) ex = `EX_VALUE;
                    else if (fc == `FC_RD_HREG && (qty == 16'h0000 || qty > `MAX_REGS))
                        ex = `EX_VALUE;
                    else if (!rng_ok) ex = `EX_ADDR;
                    else if (!i_drv_ready) ex = `EX_FUNC;
                end
                `FC_DIAG: begin
                    if (rx_len_q != `LEN_FIX || !sub_ok) ex = `EX_VALUE;
                end
                `FC_EVT_CNT, `FC_REP_ID: begin
                    if (rx_len_q != `LEN_BARE) ex = `EX_VALUE;
                end
                default: ex = `EX_FUNC;
            endcase
        end
    end

    // ***************************************
    // coil image merge and local register read
    // ***************************************
    always @* begin
        cmask = ~({72{1'b1}} << ((fc == `FC_WR_COIL) ? 7'd1 : qty[6:0]));
        for (k = 0; k < 9; k = k + 1) begin
            cwd[8*k +: 8] = rxb[7 + k];
        end
        if (fc == `FC_WR_COIL) begin
            cwd = {71'h0, qty == `COIL_ON};
        end
        cnew = ({7'h00, coil_v} & ~(cmask << adr[6:0])) | ((cwd & cmask) << adr[6:0]);
        lrd = 16'h0000;
        if (cur == `REG_ERR) lrd = err_q;
        else if (cur == `REG_IDX) lrd = idx_q;
        else if (cur == `REG_CTW) lrd = o_ctrl_word;
        else if (cur == `REG_REF) lrd = o_bus_ref;
        else if (cur == `REG_STW) lrd = i_status_word;
        else if (cur == `REG_MAV) lrd = i_main_actual;
    end

    task build_exc;
        input [7:0] code;
        begin
            txb[1]    <= fc | `EXC_BIT;
            txb[2]    <= code;
            tx_len_q  <= `LEN_EXC;
            exc_cnt_q <= exc_cnt_q + 16'h0001;
            diag_q[`DIAG_EXC_BIT] <= 1'b1;
            st_q      <= bcast ? S_IDLE : S_SEND;
        end
    endtask

    // ***************************************
    // main sequencer
    // ***************************************
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= S_IDLE;
            rx_len_q <= 6'h00;
            rx_ovf_q <= 1'b0;
            tx_len_q <= 6'h00;
            tx_pos_q <= 6'h00;
            crc_q <= `CRC_INIT;
            idx_q <= 16'h0000;
            err_q <= 16'h0000;
            diag_q <= 16'h0000;
            bus_cnt_q <= 16'h0000;
            cerr_cnt_q <= 16'h0000;
            exc_cnt_q <= 16'h0000;
            fol_cnt_q <= 16'h0000;
            evt_cnt_q <= 16'h0000;
            ri_q <= 4'h0;
            text_q <= 1'b0;
            words_q <= 4'h0;
            o_tx_valid <= 1'b0;
            o_tx_data <= 8'h00;
            o_tx_last <= 1'b0;
            o_busy <= 1'b0;
            o_par_req <= 1'b0;
            o_par_we <= 1'b0;
            o_par_num <= 16'h0000;
            o_par_ofs <= 4'h0;
            o_par_idx <= 16'h0000;
            o_par_wdata <= 16'h0000;
            o_par_persist <= 1'b0;
            o_ctrl_word <= 16'h0000;
            o_bus_ref <= 16'h0000;
        end else begin
            o_par_req <= 1'b0;
            o_busy <= (st_q != S_IDLE);
            case (st_q)
                S_IDLE: begin
                    if (i_rx_valid) begin
                        if (rx_len_q == `RX_FULL) rx_ovf_q <= 1'b1;
                        else begin
                            rxb[rx_len_q[4:0]] <= i_rx_data;
                            rx_len_q <= rx_len_q + 6'h01;
                        end
                    end
                    if (i_rx_end) begin
                        bus_cnt_q <= bus_cnt_q + 16'h0001;
                        if (i_rx_crc_ok) st_q <= S_CHK;
                        else begin
                            cerr_cnt_q <= cerr_cnt_q + 16'h0001;
                            diag_q[`DIAG_CRC_BIT] <= 1'b1;
                            rx_len_q <= 6'h00;
                            rx_ovf_q <= 1'b0;
                        end
                    end
                end
                S_CHK: begin
                    rx_len_q <= 6'h00;
                    rx_ovf_q <= 1'b0;
                    ri_q <= 4'h0;
                    text_q <= 1'b0;
                    tx_pos_q <= 6'h00;
                    crc_q <= `CRC_INIT;
                    for (n = 0; n < 6; n = n + 1) begin
                        txb[n] <= rxb[n];
                    end
                    tx_len_q <= `LEN_FIX;
                    st_q <= bcast ? S_IDLE : S_SEND;
                    // reads make no sense without a reply
                    if (!for_us || (bcast && (rd_fc || fc == `FC_DIAG
                        || fc == `FC_EVT_CNT || fc == `FC_REP_ID))) begin
                        st_q <= S_IDLE;
                    end else if (ex != 8'h00) begin
                        fol_cnt_q <= fol_cnt_q + 16'h0001;
                        build_exc(ex);
                    end else begin
                        fol_cnt_q <= fol_cnt_q + 16'h0001;
                        evt_cnt_q <= evt_cnt_q + 16'h0001;
                        case (fc)
                            `FC_RD_COILS: begin
                                txb[2] <= cbytes[7:0];
                                for (n = 0; n < 9; n = n + 1) begin
                                    txb[3 + n] <= coil_rd[8*n +: 8];
                                end
                                tx_len_q <= `LEN_EXC + cbytes[5:0];
                            end
                            `FC_WR_COIL, `FC_WR_COILS: begin
                                o_ctrl_word <= cnew[15:0];
                                o_bus_ref <= cnew[31:16];
                                o_par_persist <= cnew[64];
                            end
                            `FC_DIAG: begin
                                if (adr == `SUB_RESTART || adr == `SUB_CLEAR) begin
                                    bus_cnt_q <= 16'h0000;
                                    cerr_cnt_q <= 16'h0000;
                                    exc_cnt_q <= 16'h0000;
                                    fol_cnt_q <= 16'h0000;
                                    evt_cnt_q <= 16'h0000;
                                    diag_q <= 16'h0000;
                                end
                                if (adr == `SUB_DIAG_REG) {txb[4], txb[5]} <= diag_q;
                                if (adr == `SUB_BUS_MSG) {txb[4], txb[5]} <= bus_cnt_q;
                                if (adr == `SUB_COMM_ERR) {txb[4], txb[5]} <= cerr_cnt_q;
                                if (adr == `SUB_EXC_ERR) {txb[4], txb[5]} <= exc_cnt_q;
                                if (adr == `SUB_FOL_MSG) {txb[4], txb[5]} <= fol_cnt_q;
                            end
                            `FC_EVT_CNT: begin
                                {txb[2], txb[3]} <= 16'h0000;
                                {txb[4], txb[5]} <= evt_cnt_q;
                                evt_cnt_q <= evt_cnt_q;
                            end
                            `FC_REP_ID: begin
                                txb[2] <= 8'h02;
                                txb[3] <= `FOLLOWER_ID; // arbitrary value
                                txb[4] <= `RUN_ON;
                                tx_len_q <= `LEN_FIX - 6'h01;
                            end
                            default: st_q <= S_REG;
                        endcase
                    end
                end
                S_REG: begin
                    if ({12'h000, ri_q} == cnt ||
                        (fc == `FC_RD_HREG && text_q && ri_q >= words_q)) begin
                        if (fc == `FC_RD_HREG) begin
                            txb[2] <= {3'b000, ri_q, 1'b0};
                            tx_len_q <= `LEN_EXC + {1'b0, ri_q, 1'b0};
                        end
                        st_q <= bcast ? S_IDLE : S_SEND;
                    end else if (cur_par) begin
                        o_par_req <= 1'b1;
                        o_par_we <= (fc != `FC_RD_HREG);
                        o_par_num <= par_num;
                        o_par_ofs <= par_ofs[3:0];
                        o_par_idx <= idx_q;
                        o_par_wdata <= (fc == `FC_WR_REG) ? qty
                                     : {rxb[7 + {ri_q, 1'b0}], rxb[8 + {ri_q, 1'b0}]};
                        st_q <= S_PWAIT;
                    end else begin
                        if (fc == `FC_RD_HREG) begin
                            {txb[3 + {ri_q, 1'b0}], txb[4 + {ri_q, 1'b0}]} <= lrd;
                        end else if (cur == `REG_IDX) idx_q <= o_par_wdata_src(1'b0);
                        else if (cur == `REG_CTW) o_ctrl_word <= o_par_wdata_src(1'b0);
                        else if (cur == `REG_REF) o_bus_ref <= o_par_wdata_src(1'b0);
                        ri_q <= ri_q + 4'h1;
                    end
                end
                S_PWAIT: begin
                    if (i_par_ack) begin
                        err_q <= i_par_code;
                        if (ri_q == 4'h0) begin
                            text_q <= i_par_text;
                            words_q <= i_par_words;
                        end
                        if (i_par_err) build_exc(`EX_FAIL);
                        else begin
                            // writes keep the echoed header intact
                            if (fc == `FC_RD_HREG) begin
                                txb[3 + {ri_q, 1'b0}] <= rd_hi;
                                txb[4 + {ri_q, 1'b0}] <= rd_lo;
                            end
                            ri_q <= ri_q + 4'h1;
                            st_q <= S_REG;
                        end
                    end
                end
                S_SEND: begin
                    if (o_tx_valid && i_tx_ready && o_tx_last) begin
                        o_tx_valid <= 1'b0;
                        o_tx_last <= 1'b0;
                        st_q <= S_IDLE;
                    end else if (!o_tx_valid || i_tx_ready) begin
                        o_tx_valid <= 1'b1;
                        tx_pos_q <= tx_pos_q + 6'h01;
                        if (tx_pos_q < tx_len_q) begin
                            o_tx_data <= txb[tx_pos_q[4:0]];
                            crc_q <= crc_d;
                        end else if (tx_pos_q == tx_len_q) begin
                            o_tx_data <= crc_q[7:0];
                        end else begin
                            o_tx_data <= crc_q[15:8];
                            o_tx_last <= 1'b1;
                        end
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    function [15:0] o_par_wdata_src;
        input dummy;
        begin
            o_par_wdata_src = (fc == `FC_WR_REG) ? qty
                            : {rxb[7 + {ri_q, 1'b0}], rxb[8 + {ri_q, 1'b0}]};
        end
    endfunction
endmodule // fpch_cmd

// File: tb/fpch_cmd_asserts.sv
`timescale 1ns/1ps
module fpch_cmd_asserts (
    input  wire       i_core_clk,
    input  wire       i_rstn,
    input  wire [7:0] i_own_addr,
    input  wire       i_tx_ready,
    input  wire       i_par_ack,
    input  wire       o_tx_valid,
    input  wire [7:0] o_tx_data,
    input  wire       o_tx_last,
    input  wire       o_busy,
    input  wire       o_par_req
);
    // ****************************************
    // reply and parameter handshake checks
    // ****************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    req_pulse_a: assert property (o_par_req |=> !o_par_req)
        else $error("parameter request held past one cycle");
    req_busy_a: assert property (o_par_req |-> o_busy && !o_tx_valid)
        else $error("parameter request outside a command or during reply");
    tx_hold_a: assert property (o_tx_valid && !i_tx_ready
        |=> o_tx_valid && $stable(o_tx_data))
        else $error("reply byte changed while stalled");
    last_valid_a: assert property (o_tx_last |-> o_tx_valid)
        else $error("last flag without a reply byte");
    valid_busy_a: assert property (o_tx_valid |-> o_busy)
        else $error("reply byte while idle");
    reply_addr_a: assert property ($rose(o_tx_valid) |-> o_tx_data == i_own_addr)
        else $error("reply does not open with own address");
    reply_end_a: assert property (o_tx_valid && i_tx_ready && o_tx_last
        |=> !o_tx_valid)
        else $error("reply continues after check value");
    ack_idle_a: assert property (i_par_ack |-> !o_par_req)
        else $error("new request while access outstanding");
endmodule // fpch_cmd_asserts
bind fpch_cmd fpch_cmd_asserts fpch_cmd_asserts_i (.i_core_clk, .i_rstn, .i_own_addr,
    .i_tx_ready, .i_par_ack, .o_tx_valid, .o_tx_data, .o_tx_last, .o_busy, .o_par_req);

// File: tb/fpch_par_model.sv
`timescale 1ns/1ps
module fpch_par_model (
    input  wire        i_core_clk,
    input  wire        i_rstn,
    input  wire        i_par_req,
    input  wire [15:0] i_par_num,
    input  wire [3:0]  i_par_ofs,
    input  wire [15:0] i_par_idx,
    output reg         o_par_ack,
    output wire [15:0] o_par_rdata,
    output wire        o_par_err,
    output wire [15:0] o_par_code,
    output wire        o_par_text,
    output wire [3:0]  o_par_words
);
    // ****************************************
    // parameter store stand-in
    // ****************************************
    reg  [1:0]  wait_q;
    wire [15:0] value = o_par_text ? 16'h4100 : i_par_num + i_par_idx + {12'h000, i_par_ofs};
    // odd numbers answer slowly so both latencies are exercised
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wait_q    <= 2'h0;
            o_par_ack <= 1'b0;
        end else begin
            o_par_ack <= (wait_q == 2'h1) && !i_par_req;
            wait_q    <= i_par_req ? (i_par_num[0] ? 2'h3 : 2'h1) : wait_q - (wait_q != 2'h0);
        end
    end
    assign o_par_rdata = o_par_ack ? value : ~value;
    assign o_par_err   = (i_par_num == 16'h03E7);
    assign o_par_code  = i_par_num;
    assign o_par_text  = (i_par_num == 16'h01F4);
    assign o_par_words = 4'h2;
endmodule // fpch_par_model

// File: tb/fpch_cmd_bench.sv
`timescale 1ns/1ps
`include "fpch_consts.vh"
`define CHK(n, e, g) check_count++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end
module fpch_cmd_bench;
    // ****************************************
    // requests and the replies they should give
    // ****************************************
    typedef struct packed {logic [7:0] rn; logic [95:0] rq;
        logic [7:0] en; logic [63:0] ex;} fpch_row_t;
    fpch_row_t rows [0:22] = '{
        '{6, 96'h010600080002, 6, 64'h010600080002}, '{6, 96'h010300080001, 5, 64'h0103020002},
        '{6, 96'h01030C2F0001, 5, 64'h010302013A}, '{6, 96'h01030D510002, 7, 64'h01030401570158},
        '{6, 96'h010327050001, 3, 64'h018304}, '{6, 96'h010300060001, 5, 64'h01030203E7},
        '{6, 96'h010600060001, 3, 64'h018602}, '{6, 96'h0103C4210002, 3, 64'h018302},
        '{6, 96'h010300080000, 3, 64'h018303}, '{2, 96'h0107, 3, 64'h018701},
        '{6, 96'h0108000F0000, 3, 64'h018803}, '{6, 96'h010800020000, 6, 64'h010800020002},
        '{6, 96'h0108000A0000, 6, 64'h0108000A0000}, '{6, 96'h0108000D0000, 6, 64'h0108000D0000},
        '{6, 96'h010100200010, 5, 64'h0101020706}, '{6, 96'h0103C4170001, 5, 64'h0103020607},
        '{6, 96'h01050040FF00, 6, 64'h01050040FF00}, '{6, 96'h0106C34FFFFF, 6, 64'h0106C34FFFFF},
        '{11, 96'h01100D51000204000A000B, 6, 64'h01100D510002},
        '{9, 96'h010F00100010022000, 6, 64'h010F00100010}, '{2, 96'h0111, 5, 64'h0111025AFF},
        '{6, 96'h010313870004, 7, 64'h01030441204120}, '{2, 96'h010B, 6, 64'h010B00000009}};
    logic [47:0] quiet [0:2] = '{48'h000600080005, 48'h020300080001, 48'h010300080001};
    logic       i_core_clk = 1'b0, i_rstn = 1'b0, i_rx_valid = 1'b0, i_rx_end = 1'b0;
    logic       i_rx_crc_ok = 1'b0, i_tx_ready = 1'b0, i_drv_ready = 1'b1;
    logic [7:0] i_rx_data = 8'h00;
    logic [7:0] rsp [0:15];
    wire        o_tx_valid, o_tx_last, o_busy, o_par_req, o_par_we, o_par_persist;
    wire        i_par_ack, i_par_err, i_par_text;
    wire [7:0]  o_tx_data;
    wire [3:0]  o_par_ofs, i_par_words;
    wire [15:0] o_par_num, o_par_idx, o_par_wdata, i_par_rdata, i_par_code, o_ctrl_word, o_bus_ref;
    int         rc, errors = 0, check_count = 0, cyc = 0;
    always #25 i_core_clk = ~i_core_clk;
    fpch_cmd fpch_cmd_i (.i_core_clk, .i_rstn, .i_own_addr(8'h01), .i_rx_valid, .i_rx_data,
        .i_rx_end, .i_rx_crc_ok, .i_tx_ready, .o_tx_valid, .o_tx_data, .o_tx_last, .o_busy,
        .i_drv_ready, .o_par_req, .o_par_we, .o_par_num, .o_par_ofs, .o_par_idx, .o_par_wdata,
        .o_par_persist, .i_par_ack, .i_par_rdata, .i_par_err, .i_par_code, .i_par_text,
        .i_par_words, .i_status_word(16'h0607), .i_main_actual(16'h1234), .o_ctrl_word,
        .o_bus_ref);
    fpch_par_model fpch_par_model_i (.i_core_clk, .i_rstn, .i_par_req(o_par_req),
        .i_par_num(o_par_num), .i_par_ofs(o_par_ofs), .i_par_idx(o_par_idx),
        .o_par_ack(i_par_ack), .o_par_rdata(i_par_rdata), .o_par_err(i_par_err),
        .o_par_code(i_par_code), .o_par_text(i_par_text), .o_par_words(i_par_words));
    function automatic [15:0] crc_step(input [15:0] c, input [7:0] b);
        crc_step = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++)
            crc_step = crc_step[0] ? (crc_step >> 1) ^ `CRC_POLY : crc_step >> 1;
    endfunction
    task automatic send(input [95:0] rq, input int n, input logic ok);
        for (int k = n - 1; k >= 0; k--) begin
            i_rx_valid = 1'b1;
            i_rx_data = rq[8*k +: 8];
            @(posedge i_core_clk) #1;
        end
        i_rx_valid = 1'b0;
        i_rx_end = 1'b1;
        i_rx_crc_ok = ok;
        @(posedge i_core_clk) #1;
        i_rx_end = 1'b0;
    endtask
    // ready drops every third cycle so every reply sees stalls
    task automatic collect();
        logic dn;
        dn = 1'b0;
        rc = 0;
        foreach (rsp[i]) rsp[i] = 8'hxx;
        for (int k = 0; k < 300 && !dn; k++) begin
            i_tx_ready = (k % 3 != 2);
            if (o_tx_valid === 1'b1 && i_tx_ready && rc < 16) begin
                rsp[rc] = o_tx_data;
                rc++;
                dn = o_tx_last;
            end
            @(posedge i_core_clk) #1;
        end
        i_tx_ready = 1'b0;
        for (int k = 0; k < 50 && o_busy !== 1'b0; k++) @(posedge i_core_clk) #1;
    endtask
    task automatic run(input fpch_row_t r);
        logic [15:0] c;
        c = `CRC_INIT;
        send(r.rq, r.rn, 1'b1);
        collect();
        `CHK("length", r.en + 2, rc)
        for (int k = 0; k < r.en; k++) begin
            `CHK("byte", r.ex[8*(r.en-1-k) +: 8], rsp[k])
            c = crc_step(c, r.ex[8*(r.en-1-k) +: 8]);
        end
        `CHK("crc", c, {rsp[r.en+1], rsp[r.en]})
        $display("case %h done", r.rq[47:0]);
    endtask
    task summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (5) @(posedge i_core_clk);
        #1 i_rstn = 1'b1;
        foreach (rows[i]) run(rows[i]);
        `CHK("control", 16'hFFFF, o_ctrl_word)
        `CHK("reference", 16'h0020, o_bus_ref)
        `CHK("persist", 1'b1, o_par_persist)
        i_drv_ready = 1'b0;
        run('{6, 96'h010300080001, 3, 64'h018301});
        i_drv_ready = 1'b1;
        foreach (quiet[i]) begin
            send(quiet[i], 6, i != 2);
            collect();
            `CHK("silent", 0, rc)
            $display("quiet %0d done", i);
        end
        run('{6, 96'h010300080001, 5, 64'h0103020005});
        i_rstn = 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1 i_rstn = 1'b1;
        `CHK("control", 16'h0000, o_ctrl_word)
        `CHK("persist", 1'b0, o_par_persist)
        run('{6, 96'h010300080001, 5, 64'h0103020000});
        summarize();
    end
endmodule // fpch_cmd_bench
